// [history_queue_ram.sv]
// Circular byte storage of the temperature history queue.
// Assumes one write and one registered read per clock.
`timescale 1ns/1ps
module history_queue_ram (
  input wire logic   mclk,
  queue_port_if.ram  port
);
  // No reset: contents survive a power cycle as nonvolatile history
  logic [7:0] mem [temp_history_pkg::QUEUE_SIZE];

  always_ff @(posedge mclk) begin
    if (port.wrEn) begin
      mem[port.wrAddr] <= port.wrData;
    end
  end

  always_ff @(posedge mclk) begin
    port.rdData <= mem[port.rdAddr];
  end
endmodule

// [host_table_reader.sv]
// Host side model: fetches history table bytes one at a time over the byte read port.
// Assumes the logger answers one cycle after a taken read request.
`timescale 1ns/1ps
module host_table_reader (
  input  wire logic       mclk,
  input  wire logic [7:0] rdData,
  input  wire logic       rdValid,
  output logic            rdEn,
  output logic      [8:0] rdAddr
);
  // Only the temperature history table is ever requested by this host
  localparam logic [15:0] TABLE_ID = 16'h0002;
  int idleGap = 0;

  initial begin
    rdEn = 1'b0;
    rdAddr = 9'h000;
  end

  task automatic read_byte(input logic [8:0] addr, output logic [7:0] data, output logic ok);
    int n;
    ok = 1'b0;
    data = 8'h00;
    @(negedge mclk);
    rdEn = 1'b1;
    rdAddr = addr;
    @(negedge mclk);
    rdEn = 1'b0;
    // Released address is inverted so a stale hold is never mistaken for a request
    rdAddr = ~addr;
    // The answer stands for one cycle only, so look before waiting again
    for (n = 0; n < 4 && !ok; n++) begin
      if (rdValid === 1'b1) begin
        ok = 1'b1;
        data = rdData;
      end else begin
        @(negedge mclk);
      end
    end
    // A slow host leaves idle cycles between reads
    repeat (idleGap) @(negedge mclk);
  endtask
endmodule

// [queue_port_if.sv]
// Write and read port between the logger control and its queue storage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface queue_port_if;
  logic       wrEn;
  logic [6:0] wrAddr;
  logic [7:0] wrData;
  logic [6:0] rdAddr;
  logic [7:0] rdData;
  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport ram  (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// [tb_top.sv]
// Self-checking bench for the temperature history logger.
// Assumes a minute shortened to 10 clocks; inputs change at the falling edge.
`timescale 1ns/1ps
module tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  sensorTemp = 8'h19;
  logic        sensorValid = 1'b1;
  logic        cmdBusy = 1'b0;
  logic        powerUp = 1'b0;
  logic        clearReq = 1'b0;
  logic        setInterval = 1'b0;
  logic [15:0] intervalValue = 16'h0000;
  logic        intervalPersistent = 1'b0;
  logic        rdEn;
  logic [8:0]  rdAddr;
  logic [7:0]  rdData;
  logic        rdValid;
  logic        clearing;
  int          fails = 0;
  int          checked = 0;

  always #2 mclk = ~mclk;

  temperature_history_logger #(.MINUTE_CYCLES(10)) i_temperature_history_logger (
    .mclk(mclk), .rst(rst), .sensorTemp(sensorTemp), .sensorValid(sensorValid), .cmdBusy(cmdBusy),
    .powerUp(powerUp), .clearReq(clearReq), .setInterval(setInterval), .intervalValue(intervalValue),
    .intervalPersistent(intervalPersistent), .rdEn(rdEn), .rdAddr(rdAddr), .rdData(rdData),
    .rdValid(rdValid), .clearing(clearing));

  host_table_reader i_host_table_reader (.mclk(mclk), .rdData(rdData), .rdValid(rdValid), .rdEn(rdEn),
    .rdAddr(rdAddr));

  task print_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic fetch(input logic [8:0] a, output logic [7:0] d);
    logic ok;
    i_host_table_reader.read_byte(a, d, ok);
    if (!ok) begin
      fails++;
      $display("wrong value at %0t addr %h valid got %h expected %h", $time, a, 1'b0, 1'b1);
      print_verdict;
    end
  endtask

  task automatic compare_byte(input logic [8:0] a, input logic [7:0] exp);
    logic [7:0] got;
    fetch(a, got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t addr %h got %h expected %h", $time, a, got, exp);
    end
  endtask

  task automatic compare_differs(input logic [8:0] a, input logic [7:0] bad);
    logic [7:0] got;
    fetch(a, got);
    checked++;
    if (got === bad || $isunknown(got)) begin
      fails++;
      $display("wrong value at %0t addr %h got %h expected not %h", $time, a, got, bad);
    end
  endtask

  task automatic compare_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t flag got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_clear_done;
    int n;
    for (n = 0; n < 400 && clearing !== 1'b0; n++) @(negedge mclk);
    if (clearing !== 1'b0) begin
      fails++;
      $display("wrong value at %0t clear got %h expected %h", $time, clearing, 1'b0);
      print_verdict;
    end
  endtask

  task automatic wait_index(input logic [7:0] v, input int bound);
    logic [7:0] got;
    int n;
    got = 8'hFF;
    for (n = 0; n < bound && got !== v; n++) fetch(9'h020, got);
    if (got !== v) begin
      fails++;
      $display("wrong value at %0t index got %h expected %h", $time, got, v);
      print_verdict;
    end
  endtask

  task test_header;
    int k;
    logic [7:0] lim [4];
    lim = '{8'h3C, 8'h46, 8'h05, 8'hFB};
    compare_byte(9'h000, 8'h02);
    compare_byte(9'h001, 8'h00);
    compare_byte(9'h002, 8'h01);
    compare_byte(9'h003, 8'h00);
    compare_byte(9'h004, 8'h01);
    compare_byte(9'h01E, 8'h80);
    compare_byte(9'h01F, 8'h00);
    for (k = 0; k < 4; k++) compare_byte(9'h006 + 9'(k), lim[k]);
    for (k = 0; k < 4; k++) compare_differs(9'h006 + 9'(k), 8'h80);
    compare_byte(9'h00A, 8'h00);
    compare_byte(9'h01D, 8'h00);
    compare_byte(9'h0A2, 8'h00);
    compare_byte(9'h1FF, 8'h00);
    $display("test header done");
  endtask

  task test_interval_clear;
    @(negedge mclk);
    setInterval = 1'b1;
    @(negedge mclk);
    setInterval = 1'b0;
    compare_flag(clearing, 1'b0);
    @(negedge mclk);
    intervalValue = 16'hFFFF;
    setInterval = 1'b1;
    @(negedge mclk);
    setInterval = 1'b0;
    compare_flag(clearing, 1'b1);
    wait_clear_done;
    compare_byte(9'h004, 8'hFF);
    compare_byte(9'h005, 8'hFF);
    compare_byte(9'h002, 8'h01);
    compare_byte(9'h006, 8'h3C);
    compare_byte(9'h020, 8'h00);
    compare_byte(9'h022, 8'h19);
    compare_byte(9'h023, 8'h80);
    compare_byte(9'h0A1, 8'h80);
    $display("test interval clear done");
  endtask

  task test_power_cycle;
    // Entries resume at once with the reverted interval, so reads follow quickly
    @(negedge mclk);
    powerUp = 1'b1;
    @(negedge mclk);
    powerUp = 1'b0;
    compare_byte(9'h020, 8'h01);
    compare_byte(9'h023, 8'h80);
    compare_byte(9'h004, 8'h01);
    compare_byte(9'h022, 8'h19);
    // A persistent interval must survive the next power-up
    @(negedge mclk);
    intervalValue = 16'h0002;
    intervalPersistent = 1'b1;
    setInterval = 1'b1;
    @(negedge mclk);
    setInterval = 1'b0;
    intervalPersistent = 1'b0;
    wait_clear_done;
    powerUp = 1'b1;
    @(negedge mclk);
    powerUp = 1'b0;
    compare_byte(9'h004, 8'h02);
    compare_byte(9'h005, 8'h00);
    $display("test power cycle done");
  endtask

  task test_entries;
    i_host_table_reader.idleGap = 1;
    cmdBusy = 1'b1;
    clearReq = 1'b1;
    @(negedge mclk);
    clearReq = 1'b0;
    sensorTemp = 8'h2A;
    wait_clear_done;
    wait_index(8'h01, 50);
    compare_differs(9'h023, 8'h2A);
    cmdBusy = 1'b0;
    wait_index(8'h03, 50);
    compare_byte(9'h025, 8'h2A);
    // New value so the wrapped slot zero cannot be mistaken for the clear's write
    sensorTemp = 8'h31;
    wait_index(8'h00, 2000);
    compare_byte(9'h022, 8'h31);
    $display("test entries done");
  endtask

  initial begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    wait_clear_done;
    test_header;
    test_interval_clear;
    test_power_cycle;
    test_entries;
    print_verdict;
  end
endmodule

// [temp_history_pkg.sv]
// Constants, table layout and state type for the temperature history logger.
// Assumes a single 250 MHz clock and byte-wide table reads.
package temp_history_pkg;

  localparam logic [15:0] FORMAT_VERSION   = 16'h0002;
  localparam logic [15:0] DEFAULT_INTERVAL = 16'h0001;
  localparam logic [15:0] DEFAULT_PERIOD   = 16'h0001;
  localparam logic [7:0]  INVALID_TEMP     = 8'h80;
  localparam logic [7:0]  RESERVED_BYTE    = 8'h00;

  localparam int QUEUE_SIZE = 128;
  localparam int TABLE_SIZE = 512;

  localparam logic [8:0] OFS_VERSION  = 9'h000;
  localparam logic [8:0] OFS_PERIOD   = 9'h002;
  localparam logic [8:0] OFS_INTERVAL = 9'h004;
  localparam logic [8:0] OFS_MAX_OP   = 9'h006;
  localparam logic [8:0] OFS_OVER     = 9'h007;
  localparam logic [8:0] OFS_MIN_OP   = 9'h008;
  localparam logic [8:0] OFS_UNDER    = 9'h009;
  localparam logic [8:0] OFS_QSIZE    = 9'h01E;
  localparam logic [8:0] OFS_QINDEX   = 9'h020;
  localparam logic [8:0] OFS_QUEUE    = 9'h022;
  localparam logic [8:0] OFS_QEND     = 9'h0A2;

  localparam longint CLK_PERIOD_PS  = 4000;
  localparam longint MINUTE_PS      = 64'd60_000_000_000_000;
  localparam longint MINUTE_CYCLES  = MINUTE_PS / CLK_PERIOD_PS;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_CLEAR = 1'b1
  } state_type;

endpackage

// [temperature_history_logger.sv]
// Temperature history logger: samples, circular queue and 512-byte table read port.
// Assumes inputs synchronous to mclk; powerUp marks a restored power cycle.
`timescale 1ns/1ps
module temperature_history_logger #(
  parameter logic [15:0] SAMPLE_PERIOD         = temp_history_pkg::DEFAULT_PERIOD,
  parameter logic [7:0]  UPPER_OPERATING_BOUND = 8'h3C,
  parameter logic [7:0]  OVER_LIMIT            = 8'h46,
  parameter logic [7:0]  LOWER_OPERATING_BOUND = 8'h05,
  parameter logic [7:0]  UNDER_LIMIT           = 8'hFB,
  parameter longint      MINUTE_CYCLES         = temp_history_pkg::MINUTE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  sensorTemp,
  input  wire logic        sensorValid,
  input  wire logic        cmdBusy,
  input  wire logic        powerUp,
  input  wire logic        clearReq,
  input  wire logic        setInterval,
  input  wire logic [15:0] intervalValue,
  input  wire logic        intervalPersistent,
  input  wire logic        rdEn,
  input  wire logic [8:0]  rdAddr,
  output logic      [7:0]  rdData,
  output logic             rdValid,
  output logic             clearing
);
  localparam int DIV_W = 36;

  if (MINUTE_CYCLES < 1 || MINUTE_CYCLES >= (64'd1 << DIV_W)) begin
    $error("MINUTE_CYCLES out of range");
  end
  if (UPPER_OPERATING_BOUND == temp_history_pkg::INVALID_TEMP || OVER_LIMIT == temp_history_pkg::INVALID_TEMP ||
      LOWER_OPERATING_BOUND == temp_history_pkg::INVALID_TEMP || UNDER_LIMIT == temp_history_pkg::INVALID_TEMP) begin
    $error("Limit bytes may not hold the invalid code");
  end

  queue_port_if q ();

  history_queue_ram ram (
    .mclk (mclk),
    .port (q)
  );

  temp_history_pkg::state_type state_q;
  logic [DIV_W-1:0] divCnt_q;
  logic             minuteTick;
  logic [15:0]      sampleAge_q;
  logic [15:0]      entryAge_q;
  logic [15:0]      interval_q;
  logic [15:0]      savedInterval_q;
  logic [7:0]       latest_q;
  logic [6:0]       ptr_q;
  logic [6:0]       clrIdx_q;
  logic             sampleTake;
  logic             entryFire;
  logic             powerFire;
  logic             clearStart;
  logic [7:0]       curTemp;
  logic [7:0]       hdr_q;
  logic             inQueue_q;

  // One-minute enable from the clock divider
  assign minuteTick = (divCnt_q == DIV_W'(MINUTE_CYCLES - 1));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      divCnt_q <= '0;
    end else if (minuteTick) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_q + 1'b1;
    end
  end

  assign curTemp    = sensorValid ? sensorTemp : temp_history_pkg::INVALID_TEMP;
  // A sample waits while commands run, so it can only be late, never early
  assign sampleTake = (SAMPLE_PERIOD != 16'h0000) && (sampleAge_q >= SAMPLE_PERIOD) && !cmdBusy && sensorValid;
  assign clearStart = clearReq || (setInterval && intervalValue != 16'h0000);
  assign powerFire  = powerUp && !clearStart;
  assign entryFire  = (entryAge_q >= interval_q) && (state_q == temp_history_pkg::ST_IDLE) && !clearStart && !powerFire;
  assign clearing   = (state_q == temp_history_pkg::ST_CLEAR);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sampleAge_q <= '0;
      latest_q    <= temp_history_pkg::INVALID_TEMP;
    end else begin
      if (sampleTake) begin
        sampleAge_q <= '0;
        latest_q    <= sensorTemp;
      end else if (minuteTick && sampleAge_q != 16'hFFFF) begin
        sampleAge_q <= sampleAge_q + 1'b1;
      end
      if (SAMPLE_PERIOD == 16'h0000) begin
        latest_q <= temp_history_pkg::INVALID_TEMP;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      entryAge_q <= '0;
    end else if (entryFire || clearStart || powerFire) begin
      entryAge_q <= '0;
    end else if (minuteTick && entryAge_q != 16'hFFFF) begin
      entryAge_q <= entryAge_q + 1'b1;
    end
  end

  // Zero interval is ignored; a volatile setting is lost at the next power-up
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      interval_q      <= temp_history_pkg::DEFAULT_INTERVAL;
      savedInterval_q <= temp_history_pkg::DEFAULT_INTERVAL;
    end else if (setInterval && intervalValue != 16'h0000) begin
      interval_q <= intervalValue;
      if (intervalPersistent) begin
        savedInterval_q <= intervalValue;
      end
    end else if (powerUp) begin
      interval_q <= savedInterval_q;
    end
  end

  // Reset counts as a new drive and clears the history
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q  <= temp_history_pkg::ST_CLEAR;
      clrIdx_q <= '0;
      ptr_q    <= '0;
    end else begin
      case (state_q)
        temp_history_pkg::ST_IDLE: begin
          if (clearStart) begin
            state_q  <= temp_history_pkg::ST_CLEAR;
            clrIdx_q <= '0;
            ptr_q    <= '0;
          end else if (powerFire || entryFire) begin
            ptr_q <= ptr_q + 1'b1;
          end
        end
        temp_history_pkg::ST_CLEAR: begin
          if (clearStart) begin
            clrIdx_q <= '0;
          end else if (clrIdx_q == 7'(temp_history_pkg::QUEUE_SIZE - 1)) begin
            state_q <= temp_history_pkg::ST_IDLE;
          end else begin
            clrIdx_q <= clrIdx_q + 1'b1;
          end
          ptr_q <= '0;
        end
        default: begin
          state_q <= temp_history_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Power-up during a clear is absorbed: the fresh queue already reads as a break
  always_comb begin
    q.wrEn   = 1'b0;
    q.wrAddr = ptr_q + 1'b1;
    q.wrData = temp_history_pkg::INVALID_TEMP;
    if (state_q == temp_history_pkg::ST_CLEAR) begin
      q.wrEn   = !clearStart;
      q.wrAddr = clrIdx_q;
      q.wrData = (clrIdx_q == 7'h00) ? curTemp : temp_history_pkg::INVALID_TEMP;
    end else if (powerFire) begin
      q.wrEn = 1'b1;
    end else if (entryFire) begin
      q.wrEn   = 1'b1;
      q.wrData = latest_q;
    end
  end

  assign q.rdAddr = 7'(rdAddr - temp_history_pkg::OFS_QUEUE);

  // Table read: one cycle from rdEn to rdValid; reading the table is identifier 0002h
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hdr_q     <= temp_history_pkg::RESERVED_BYTE;
      inQueue_q <= 1'b0;
      rdValid   <= 1'b0;
    end else begin
      rdValid <= rdEn;
      if (rdEn) begin
        inQueue_q <= (rdAddr >= temp_history_pkg::OFS_QUEUE) && (rdAddr < temp_history_pkg::OFS_QEND);
        case (rdAddr)
          temp_history_pkg::OFS_VERSION:      hdr_q <= temp_history_pkg::FORMAT_VERSION[7:0];
          temp_history_pkg::OFS_VERSION + 1:  hdr_q <= temp_history_pkg::FORMAT_VERSION[15:8];
          temp_history_pkg::OFS_PERIOD:       hdr_q <= SAMPLE_PERIOD[7:0];
          temp_history_pkg::OFS_PERIOD + 1:   hdr_q <= SAMPLE_PERIOD[15:8];
          temp_history_pkg::OFS_INTERVAL:     hdr_q <= interval_q[7:0];
          temp_history_pkg::OFS_INTERVAL + 1: hdr_q <= interval_q[15:8];
          temp_history_pkg::OFS_MAX_OP:       hdr_q <= UPPER_OPERATING_BOUND;
          temp_history_pkg::OFS_OVER:         hdr_q <= OVER_LIMIT;
          temp_history_pkg::OFS_MIN_OP:       hdr_q <= LOWER_OPERATING_BOUND;
          temp_history_pkg::OFS_UNDER:        hdr_q <= UNDER_LIMIT;
          temp_history_pkg::OFS_QSIZE:        hdr_q <= 8'(temp_history_pkg::QUEUE_SIZE);
          temp_history_pkg::OFS_QSIZE + 1:    hdr_q <= 8'h00;
          temp_history_pkg::OFS_QINDEX:       hdr_q <= {1'b0, ptr_q};
          temp_history_pkg::OFS_QINDEX + 1:   hdr_q <= 8'h00;
          default:                            hdr_q <= temp_history_pkg::RESERVED_BYTE;
        endcase
      end
    end
  end

  assign rdData = inQueue_q ? q.rdData : hdr_q;

  version_read_a: assert property (@(posedge mclk) disable iff (rst)
    rdEn && rdAddr == 9'h000 |=> rdData == 8'h02 && rdValid)
    else $error("Version low byte wrong");

  qsize_read_a: assert property (@(posedge mclk) disable iff (rst)
    rdEn && rdAddr == 9'h01E |=> rdData == 8'h80)
    else $error("Queue size byte wrong");

  index_read_a: assert property (@(posedge mclk) disable iff (rst)
    rdEn && rdAddr == 9'h020 && !entryFire && !powerFire && !clearing |=> rdData == {1'b0, $past(ptr_q)})
    else $error("Queue index byte wrong");

  limit_valid_a: assert property (@(posedge mclk) disable iff (rst)
    rdEn && rdAddr >= 9'h006 && rdAddr <= 9'h009 |=> rdData != 8'h80)
    else $error("Limit byte holds invalid code");

  reserved_read_a: assert property (@(posedge mclk) disable iff (rst)
    rdEn && rdAddr >= 9'h00A && rdAddr <= 9'h01D |=> rdData == 8'h00)
    else $error("Reserved byte not zero");

  sample_not_early_a: assert property (@(posedge mclk) disable iff (rst)
    $changed(latest_q) |-> $past(sampleAge_q) >= SAMPLE_PERIOD && !$past(cmdBusy))
    else $error("Sample taken early or during command");

  power_break_a: assert property (@(posedge mclk) disable iff (rst)
    powerFire && !clearing |-> q.wrEn && q.wrData == 8'h80 ##1 ptr_q == $past(ptr_q) + 7'h01)
    else $error("Power-up break entry missing");

  clear_fill_a: assert property (@(posedge mclk) disable iff (rst)
    clearing && q.wrEn && q.wrAddr != 7'h00 |-> q.wrData == 8'h80 && ptr_q == 7'h00)
    else $error("Clear fill wrong");

  clear_length_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(clearing) |-> ##[127:128] !clearing || clearStart)
    else $error("Clear does not end after 128 slots");

  zero_interval_a: assert property (@(posedge mclk) disable iff (rst)
    setInterval && intervalValue == 16'h0000 && !powerUp |=> $stable(interval_q))
    else $error("Zero interval accepted");

  entry_advance_a: assert property (@(posedge mclk) disable iff (rst)
    entryFire |-> q.wrData == latest_q ##1 ptr_q == $past(ptr_q) + 7'h01)
    else $error("Entry did not advance index");
endmodule
